// [src/sfs_pkg.sv]
// package for the field-set switching block: register map, constants, carriers
// assumes a 250 MHz system clock and a 32-bit Avalon-MM slave port
package sfs_pkg;
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned HOLD_MS = 500;
   // cycles in 500 ms at 250 MHz
   localparam int unsigned HOLD_CYC_DEF = HOLD_MS * 1000 * CLK_MHZ;
   localparam int unsigned CNT_W = 28;

   localparam logic [3:0] OFF_CTRL = 4'h0;
   localparam logic [3:0] OFF_STAT = 4'h4;
   localparam logic [3:0] OFF_IRQ_STAT = 4'h8;
   localparam logic [3:0] OFF_IRQ_MASK = 4'hc;

   // ctrl bits
   localparam int unsigned CTRL_ESTOP_RST = 0;
   // stat bits
   localparam int unsigned ST_NARROW = 0;
   localparam int unsigned ST_PZC = 1;
   localparam int unsigned ST_WZC = 2;
   localparam int unsigned ST_ESTOP = 3;
   localparam int unsigned ST_STANDBY = 4;
   // irq bits
   localparam int unsigned IRQ_W = 3;
   localparam int unsigned IRQ_SWITCH = 0;
   localparam int unsigned IRQ_ESTOP = 1;
   localparam int unsigned IRQ_RSTREJ = 2;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
   // selection pair after reset: wide field set, sel_a high and sel_b low
   localparam logic [1:0] SEL_WIDE = 2'h2;

   typedef struct packed {
      logic sel_a;
      logic sel_b;
   } sfs_sel_t;

   typedef struct packed {
      logic protect_zone_clear;
      logic warn_zone_clear;
   } sfs_zone_t;

   function automatic logic [CNT_W-1:0] sfs_sat_inc(input logic [CNT_W-1:0] c,
                                                   input logic [CNT_W-1:0] lim);
      sfs_sat_inc = (c >= lim) ? lim : c + 28'h0000001;
   endfunction
endpackage

// [src/sfs_hold_timer.sv]
// counts cycles a condition holds continuously, saturating at the limit
// assumes the condition is synchronous to clk_sys_i
`timescale 1ns/1ps
module sfs_hold_timer (
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic cond_i,
   input wire logic [sfs_pkg::CNT_W-1:0] lim_i,
   output logic done_o
);
   import sfs_pkg::*;
   logic [CNT_W-1:0] cnt;

   always_ff @(posedge clk_sys_i) begin
      if (srst_i || !cond_i) begin
         cnt <= '0;
      end else begin
         cnt <= sfs_sat_inc(cnt, lim_i);
      end
   end

   assign done_o = cond_i && (cnt >= lim_i - 28'h0000001);
endmodule

// [src/sfs_regs.sv]
// avalon-mm register file with sticky w1c interrupt status and mask
// assumes single-cycle decode; waitrequest low on the cycle after a request
`timescale 1ns/1ps
module sfs_regs (
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic [7:0] stat_i,
   input wire logic [sfs_pkg::IRQ_W-1:0] evt_i,
   output logic estop_rst_pulse_o,
   output logic irq_o
);
   import sfs_pkg::*;
   logic ack;
   logic [IRQ_W-1:0] irq_stat;
   logic [IRQ_W-1:0] irq_mask;
   logic wr_now;

   // one wait cycle, then the access completes
   assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack;
   assign wr_now = avs_write_i && ack;

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         ack <= 1'b0;
      end else begin
         ack <= (avs_read_i || avs_write_i) && !ack;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         avs_readdata_o <= '0;
      end else if (avs_read_i && !ack) begin
         unique case (avs_address_i)
            OFF_STAT: avs_readdata_o <= {24'h000000, stat_i};
            OFF_IRQ_STAT: avs_readdata_o <= {29'h00000000, irq_stat};
            OFF_IRQ_MASK: avs_readdata_o <= {29'h00000000, irq_mask};
            default: avs_readdata_o <= '0;
         endcase
      end
   end

   // set wins over a simultaneous clear
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         irq_stat <= '0;
      end else if (wr_now && avs_address_i == OFF_IRQ_STAT) begin
         irq_stat <= (irq_stat & ~avs_writedata_i[IRQ_W-1:0]) | evt_i;
      end else begin
         irq_stat <= irq_stat | evt_i;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         irq_mask <= IRQ_MASK_RST;
      end else if (wr_now && avs_address_i == OFF_IRQ_MASK) begin
         irq_mask <= avs_writedata_i[IRQ_W-1:0];
      end
   end

   assign irq_o = |(irq_stat & irq_mask);
   assign estop_rst_pulse_o = wr_now && avs_address_i == OFF_CTRL
      && avs_writedata_i[CTRL_ESTOP_RST];
endmodule

// [src/sfs_top.sv]
// field-set switching logic between a laser scanner and a robot controller
// assumes all inputs synchronous to clk_sys_i; registers over avalon-mm
// Function
// - one field set: 1 when off low
// - switch to set 2 only 500 ms after rise
// - switch needs warn zone interrupted 500 ms
// - leaving protect zone: warn interrupted 500ms, else stop
// - selection channels always complementary
// - standby request follows teach mode
// - zone status routed to internal signals
// - run mode reset needs both zones clear
//
// The placing of the registers and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
module sfs_top #(
   parameter int unsigned HOLD_CYC = sfs_pkg::HOLD_CYC_DEF
) (
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic reduced_speed_off_i,
   input wire sfs_pkg::sfs_zone_t zone_i,
   input wire logic teach_mode_i,
   input wire logic run_mode_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output sfs_pkg::sfs_sel_t sel_o,
   output sfs_pkg::sfs_zone_t zone_int_o,
   output logic scanner_standby_req_o,
   output logic estop_o,
   output logic irq_o
);
   import sfs_pkg::*;
   localparam logic [CNT_W-1:0] LIM = CNT_W'(HOLD_CYC);

   logic narrow_field_set;
   logic off_held;
   logic warn_held;
   logic pz_d;
   logic zint_vld;
   logic [CNT_W-1:0] exit_cnt;
   logic [CNT_W-1:0] chk_off_cnt;
   logic [CNT_W-1:0] chk_warn_cnt;
   logic exit_arm;
   logic estop_evt;
   logic rst_req;
   logic rst_ok;
   logic sw_evt;
   logic [7:0] stat;

   // both fields free: the only zone state that lets a run-mode stop be reset
   function automatic logic sfs_both_clear(input sfs_zone_t z);
      sfs_both_clear = z.protect_zone_clear && z.warn_zone_clear;
   endfunction

   // registered copy of the link status; other functions read only this
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         zone_int_o <= '0;
      end else begin
         zone_int_o <= zone_i;
      end
   end

   sfs_hold_timer u_off_timer (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i),
      .cond_i(reduced_speed_off_i),
      .lim_i(LIM),
      .done_o(off_held)
   );

   sfs_hold_timer u_warn_timer (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i),
      .cond_i(!zone_int_o.warn_zone_clear),
      .lim_i(LIM),
      .done_o(warn_held)
   );

   // going to the narrow set waits for both holds; back to wide is immediate,
   // since the larger field is the safe side
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         narrow_field_set <= 1'b0;
      end else if (!reduced_speed_off_i) begin
         narrow_field_set <= 1'b0;
      end else if (off_held && warn_held) begin
         narrow_field_set <= 1'b1;
      end
   end

   assign sw_evt = reduced_speed_off_i && off_held && warn_held && !narrow_field_set;

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         sel_o <= SEL_WIDE;
      end else begin
         sel_o.sel_a <= !narrow_field_set;
         sel_o.sel_b <= narrow_field_set;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         scanner_standby_req_o <= 1'b0;
      end else begin
         scanner_standby_req_o <= teach_mode_i;
      end
   end

   // exit check: after the protect zone clears, count warn-zone interruption
   // the link copy reads busy during reset, so its first real sample after
   // release must not look like a person leaving the protect zone
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         zint_vld <= 1'b0;
      end else begin
         zint_vld <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         pz_d <= 1'b1;
      end else if (!zint_vld) begin
         pz_d <= 1'b1;
      end else begin
         pz_d <= zone_int_o.protect_zone_clear;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         exit_arm <= 1'b0;
         exit_cnt <= '0;
      end else if (zone_int_o.protect_zone_clear && !pz_d) begin
         exit_arm <= 1'b1;
         exit_cnt <= '0;
      end else if (exit_arm) begin
         if (zone_int_o.warn_zone_clear || exit_cnt >= LIM - 28'h0000002) begin
            exit_arm <= 1'b0;
         end
         exit_cnt <= sfs_sat_inc(exit_cnt, LIM);
      end
   end

   // warn zone cleared before the hold elapsed: exit too fast
   assign estop_evt = exit_arm && zone_int_o.warn_zone_clear;

   assign rst_ok = !run_mode_i || sfs_both_clear(zone_int_o);

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         estop_o <= 1'b0;
      end else if (estop_evt) begin
         estop_o <= 1'b1;
      end else if (rst_req && rst_ok) begin
         estop_o <= 1'b0;
      end
   end

   assign stat = {3'h0, scanner_standby_req_o, estop_o, zone_int_o.warn_zone_clear,
                  zone_int_o.protect_zone_clear, narrow_field_set};

   sfs_regs u_regs (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i),
      .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i),
      .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i),
      .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o),
      .stat_i(stat),
      .evt_i({rst_req && !rst_ok, estop_evt, sw_evt}),
      .estop_rst_pulse_o(rst_req),
      .irq_o(irq_o)
   );

   a_sel_complement: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      sel_o.sel_a != sel_o.sel_b) else $error("field select channels not complementary");

   a_wide_when_low: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      !reduced_speed_off_i |=> !narrow_field_set) else $error("narrow set with off low");

   a_no_early_switch: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      $rose(narrow_field_set) |-> $past(off_held)) else $error("switched before delay");

   a_warn_hold_first: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      $rose(narrow_field_set) |-> !$past(zone_int_o.warn_zone_clear)
   ) else $error("switched without warn interruption");

   a_standby_follows: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      !$past(srst_i) |-> scanner_standby_req_o == $past(teach_mode_i)
   ) else $error("standby mismatch");

   a_zone_route: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      !$past(srst_i) |-> zone_int_o == $past(zone_i)
   ) else $error("zone status not routed");

   a_estop_set: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      estop_evt |=> estop_o) else $error("fast exit did not stop");

   a_run_reset_gate: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      $fell(estop_o) |-> $past(!run_mode_i || (zone_int_o.protect_zone_clear
      && zone_int_o.warn_zone_clear))) else $error("reset accepted with zone busy");

   a_reset_state: assert property (@(posedge clk_sys_i)
      srst_i |=> (!narrow_field_set && !scanner_standby_req_o && exit_cnt == '0)
   ) else $error("reset state wrong");

   a_reset_sel: assert property (@(posedge clk_sys_i)
      srst_i |=> sel_o == SEL_WIDE
   ) else $error("selection pair not wide after reset");

   a_reset_timers: assert property (@(posedge clk_sys_i)
      srst_i |=> (!exit_arm && !estop_o && zone_int_o == '0)
   ) else $error("exit check or stop not cleared by reset");

   // plain run-length counters for the hold assertions, kept apart from the timers
   // so that a wrong timer threshold shows up as a failure
   always_ff @(posedge clk_sys_i) begin
      if (srst_i || !reduced_speed_off_i) begin
         chk_off_cnt <= '0;
      end else begin
         chk_off_cnt <= sfs_sat_inc(chk_off_cnt, LIM);
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i || zone_int_o.warn_zone_clear) begin
         chk_warn_cnt <= '0;
      end else begin
         chk_warn_cnt <= sfs_sat_inc(chk_warn_cnt, LIM);
      end
   end

   a_off_hold_len: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      $rose(narrow_field_set) |-> $past(chk_off_cnt) >= LIM - 28'h0000001
   ) else $error("off level held too briefly before switch");

   a_warn_hold_len: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      $rose(narrow_field_set) |-> $past(chk_warn_cnt) >= LIM - 28'h0000001
   ) else $error("warn interruption too brief before switch");

   a_sel_follows: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      !$past(srst_i) |-> sel_o.sel_b == $past(narrow_field_set)
   ) else $error("selection pair does not follow field set");

   a_wide_return: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      !reduced_speed_off_i |-> ##2 sel_o.sel_a
   ) else $error("wide set not selected after off low");

   a_exit_arm: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      $rose(zone_int_o.protect_zone_clear) && !$past(srst_i, 2) |=> exit_arm
   ) else $error("exit check not armed");

   a_exit_window: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      exit_arm |-> exit_cnt <= LIM - 28'h0000002
   ) else $error("exit check window too long");

   a_no_false_stop: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      $rose(estop_o) |-> $past(estop_evt)
   ) else $error("stop set without exit violation");

   a_estop_latched: assert property (@(posedge clk_sys_i) disable iff (srst_i)
      estop_o && !(rst_req && (!run_mode_i || sfs_both_clear(zone_int_o))) |=> estop_o
   ) else $error("stop released without accepted reset");
endmodule

// [sim/sfs_partner.sv]
// scanner and robot-controller model: drives reduced-speed-off and zone status
// from bench commands, and watches the field-set selection pair
// assumes commands change by non-blocking assignment just after rising edges
`timescale 1ns/1ps
module sfs_partner (
   input wire logic clk_sys_i,
   input wire logic rso_cmd_i,
   input wire sfs_pkg::sfs_zone_t zone_cmd_i,
   input wire sfs_pkg::sfs_sel_t sel_i,
   output logic reduced_speed_off_o,
   output sfs_pkg::sfs_zone_t zone_o,
   output logic sel_bad_o
);
   import sfs_pkg::*;
   initial begin
      reduced_speed_off_o = 1'b0;
      zone_o = 2'h0;
   end
   // registered, since the real safety outputs come from clocked controllers
   always @(posedge clk_sys_i) begin
      reduced_speed_off_o <= rso_cmd_i;
      zone_o <= zone_cmd_i;
   end
   // equal channels leave the scanner with no valid field set
   assign sel_bad_o = (sel_i.sel_a === sel_i.sel_b);
endmodule

// [sim/tb.sv]
// self-checking bench for the field-set switching block
// assumes a shortened hold count; partner model drives the safety inputs
`timescale 1ns/1ps
module tb;
   import sfs_pkg::*;
   localparam int unsigned HC = 20;
   logic clk_sys_i = 1'b0;
   logic srst_i = 1'b1;
   logic rso_c = 1'b0;
   logic teach = 1'b0;
   logic run = 1'b1;
   logic rd_s = 1'b0;
   logic wr_s = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [31:0] wd = 32'h0;
   logic [31:0] q;
   logic [31:0] rdata;
   logic wreq, rso, stby, estop, irq, bad;
   sfs_zone_t zone_c = 2'h2;
   sfs_zone_t zone, zint;
   sfs_sel_t sel;
   int err_count = 0;
   int tests_run = 0;
   int cyc = 0;

   always #2 clk_sys_i = ~clk_sys_i;

   sfs_partner u_partner (.clk_sys_i(clk_sys_i), .rso_cmd_i(rso_c), .zone_cmd_i(zone_c),
      .sel_i(sel), .reduced_speed_off_o(rso), .zone_o(zone), .sel_bad_o(bad));
   sfs_top #(.HOLD_CYC(HC)) u_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
      .reduced_speed_off_i(rso), .zone_i(zone), .teach_mode_i(teach), .run_mode_i(run),
      .avs_address_i(adr), .avs_read_i(rd_s), .avs_write_i(wr_s), .avs_writedata_i(wd),
      .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .sel_o(sel), .zone_int_o(zint),
      .scanner_standby_req_o(stby), .estop_o(estop), .irq_o(irq));

   task automatic end_sim;
      if (err_count == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", n, e, g);
         err_count++;
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask
   task automatic drv(input logic r, input logic [1:0] z, input logic t, input int n);
      @(posedge clk_sys_i);
      rso_c <= r;
      zone_c <= z;
      teach <= t;
      wt(n);
   endtask
   // the request stands until the rising edge that samples waitrequest low;
   // read data is taken at that edge and only then is the request dropped
   task automatic acc(input logic [3:0] a, input logic w, input logic [31:0] d);
      @(posedge clk_sys_i);
      adr <= a;
      wd <= d;
      wr_s <= w;
      rd_s <= !w;
      do @(posedge clk_sys_i); while (wreq !== 1'b0);
      q = rdata;
      wr_s <= 1'b0;
      rd_s <= 1'b0;
   endtask

   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         end_sim;
      end
   end
   always @(negedge clk_sys_i) if (!srst_i) chk("sel_pair", 32'h0, {31'h0, bad});

   initial begin
      repeat (3) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      wt(1);
      chk("sel", 32'h2, {30'h0, sel});
      chk("standby", 32'h0, {31'h0, stby});
      chk("estop", 32'h0, {31'h0, estop});
      drv(1'b0, 2'h2, 1'b0, HC + 4);
      drv(1'b0, 2'h3, 1'b0, 4);
      chk("zone_int", 32'h3, {30'h0, zint});
      acc(OFF_STAT, 1'b0, 32'h0);
      chk("stat", 32'h6, q);
      acc(OFF_IRQ_MASK, 1'b1, 32'h7);
      drv(1'b1, 2'h3, 1'b0, 3 * HC);
      chk("sel", 32'h2, {30'h0, sel});
      drv(1'b1, 2'h2, 1'b0, HC + 3);
      chk("sel", 32'h2, {30'h0, sel});
      wt(1);
      chk("sel", 32'h1, {30'h0, sel});
      drv(1'b0, 2'h2, 1'b0, 5);
      chk("sel", 32'h2, {30'h0, sel});
      drv(1'b1, 2'h2, 1'b0, HC + 2);
      chk("sel", 32'h2, {30'h0, sel});
      wt(1);
      chk("sel", 32'h1, {30'h0, sel});
      chk("irq", 32'h1, {31'h0, irq});
      acc(OFF_IRQ_STAT, 1'b1, 32'h1);
      wt(1);
      chk("irq", 32'h0, {31'h0, irq});
      drv(1'b0, 2'h2, 1'b1, 3);
      chk("standby", 32'h1, {31'h0, stby});
      acc(OFF_STAT, 1'b0, 32'h0);
      chk("stat", 32'h12, q);
      drv(1'b0, 2'h2, 1'b0, 2);
      chk("standby", 32'h0, {31'h0, stby});
      // warn zone freed one cycle short of the hold after the protect zone
      drv(1'b0, 2'h0, 1'b0, 4);
      drv(1'b0, 2'h2, 1'b0, HC - 1);
      drv(1'b0, 2'h3, 1'b0, 6);
      chk("estop", 32'h1, {31'h0, estop});
      drv(1'b0, 2'h2, 1'b0, HC + 4);
      acc(OFF_CTRL, 1'b1, 32'h1);
      wt(2);
      chk("estop", 32'h1, {31'h0, estop});
      acc(OFF_IRQ_STAT, 1'b0, 32'h0);
      chk("irq_stat", 32'h6, q);
      chk("irq", 32'h1, {31'h0, irq});
      acc(OFF_IRQ_STAT, 1'b1, 32'h7);
      drv(1'b0, 2'h3, 1'b0, 4);
      acc(OFF_CTRL, 1'b1, 32'h1);
      wt(2);
      chk("estop", 32'h0, {31'h0, estop});
      drv(1'b0, 2'h0, 1'b0, 4);
      drv(1'b0, 2'h2, 1'b0, HC);
      drv(1'b0, 2'h3, 1'b0, 6);
      chk("estop", 32'h0, {31'h0, estop});
      // outside run mode a reset is accepted with the protect zone busy
      drv(1'b0, 2'h0, 1'b0, 4);
      drv(1'b0, 2'h2, 1'b0, 2);
      drv(1'b0, 2'h1, 1'b0, 6);
      chk("estop", 32'h1, {31'h0, estop});
      @(posedge clk_sys_i);
      run <= 1'b0;
      acc(OFF_CTRL, 1'b1, 32'h1);
      wt(2);
      chk("estop", 32'h0, {31'h0, estop});
      acc(4'h2, 1'b0, 32'h0);
      chk("unmapped", 32'h0, q);
      end_sim;
   end
endmodule
